// >>> verilog/exec_pkg.sv
// Shared constants, opcodes, register map and types of the instruction core.
package exec_pkg;

    // ------------------------------------------------------------
    // Instruction word and operand fields
    // ------------------------------------------------------------
    localparam int IW_W    = 14;
    localparam int DATA_W  = 8;
    localparam int FADDR_W = 7;
    localparam int BSEL_W  = 3;
    localparam int K8_W    = 8;
    localparam int K11_W   = 11;
    localparam int FILE_N  = 128;
    localparam int F_LSB   = 0;
    localparam int D_POS   = 7;
    localparam int B_LSB   = 7;
    localparam int K_LSB   = 0;

    localparam logic [FADDR_W-1:0] PORT_ADDR = 7'h06;

    // ------------------------------------------------------------
    // Opcode patterns; '?' marks operand and don't-care positions
    // ------------------------------------------------------------
    localparam logic [IW_W-1:0] PAT_IDLE  = 14'b00_0000_0??0_0000;
    localparam logic [IW_W-1:0] PAT_STORE = 14'b00_0000_1???_????;
    localparam logic [IW_W-1:0] PAT_CLEAR = 14'b00_0001_1???_????;
    localparam logic [IW_W-1:0] PAT_ORWF  = 14'b00_0100_????_????;
    localparam logic [IW_W-1:0] PAT_MOVE_FILE_VALUE  = 14'b00_1000_????_????;
    localparam logic [IW_W-1:0] PAT_BSKIP = 14'b01_11??_????_????;
    localparam logic [IW_W-1:0] PAT_JUMP  = 14'b10_1???_????_????;
    localparam logic [IW_W-1:0] PAT_LDLIT = 14'b11_00??_????_????;
    localparam logic [IW_W-1:0] PAT_ORLIT = 14'b11_1000_????_????;

    typedef enum logic [1:0] {
        CLS_BYTE = 2'h0,
        CLS_BIT  = 2'h1,
        CLS_LIT  = 2'h2
    } class_e;

    typedef enum logic [3:0] {
        OP_IDLE, OP_STORE, OP_CLEAR, OP_ORWF, OP_MOVE_FILE_VALUE,
        OP_BSKIP, OP_JUMP, OP_LDLIT, OP_ORLIT
    } op_e;

    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_e;

    // ------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_ACC  = 8'h08;
    localparam logic [7:0] ADDR_PC   = 8'h0c;
    localparam logic [7:0] ADDR_IR   = 8'h10;
    localparam int CTRL_RUN  = 0;
    localparam int STAT_Z    = 0;
    localparam int STAT_PCHG = 1;
    localparam int STAT_FLSH = 2;

endpackage : exec_pkg

// >>> verilog/instr_field_decode.sv
// Splits a 14-bit instruction word into class, operation and operands.
`timescale 1ns/1ps
module instr_field_decode
    import exec_pkg::*;
(
    input  wire logic [IW_W-1:0]    word,
    output class_e                  cls,
    output op_e                     op,
    output logic [FADDR_W-1:0]      f_addr,
    output logic                    dst,
    output logic [BSEL_W-1:0]       bsel,
    output logic [K8_W-1:0]         k8,
    output logic [K11_W-1:0]        k11
);

    // ------------------------------------------------------------
    // Operation lookup
    // ------------------------------------------------------------
    // Unlisted words fall back to idle so stray encodings cannot corrupt state.
    function automatic op_e op_of(input logic [IW_W-1:0] w);
        op_e o;
        o = OP_IDLE;
        casez (w)
            PAT_IDLE:  o = OP_IDLE;
            PAT_STORE: o = OP_STORE;
            PAT_CLEAR: o = OP_CLEAR;
            PAT_ORWF:  o = OP_ORWF;
            PAT_MOVE_FILE_VALUE:  o = OP_MOVE_FILE_VALUE;
            PAT_BSKIP: o = OP_BSKIP;
            PAT_JUMP:  o = OP_JUMP;
            PAT_LDLIT: o = OP_LDLIT;
            PAT_ORLIT: o = OP_ORLIT;
            default:   o = OP_IDLE;
        endcase
        return o;
    endfunction : op_of

    always_comb begin
        op = op_of(word);
        case (op)
            OP_BSKIP: cls = CLS_BIT;
            OP_JUMP, OP_LDLIT, OP_ORLIT, OP_IDLE: cls = CLS_LIT;
            default:  cls = CLS_BYTE;
        endcase
        f_addr = word[F_LSB +: FADDR_W];
        dst    = word[D_POS];
        bsel   = word[B_LSB +: BSEL_W];
        k8     = word[K_LSB +: K8_W];
        k11    = word[K_LSB +: K11_W];
    end

endmodule : instr_field_decode

// >>> verilog/instr_exec_core.sv
// Instruction fetch, decode and execute core with an APB register slave.
// Summary of operation
// - Sort words into byte, bit, literal classes.
// - Each instruction is one 14-bit word.
// - Destination bit: 0 accumulator, 1 file register.
// - File index is seven bits, 0x00-0x7F.
// - Bit operand picks one bit of register.
// - Literal is eight or eleven bits wide.
// - Cycle is four clocks; plain instructions take one.
// - Taken skip or jump adds flushed idle cycle.
// - File operands always read; written back for store, clear, or destination 1.
// - Port access read clears port mismatch condition.
// - OR-literal into accumulator, updates zero only.
// - Load literal into accumulator, flags untouched.
// - OR accumulator with file, to destination.
// - Store accumulator to file, flags untouched.
// - Move file to destination, zero updated.
// - Don't-care word bits never affect execution.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module instr_exec_core
    import exec_pkg::*;
#(
    parameter int PC_W = K11_W
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [PC_W-1:0]        program_counter,
    input  wire logic [IW_W-1:0]   prog_word,
    input  wire logic [DATA_W-1:0] second_io_port_in,
    output logic [DATA_W-1:0]      second_io_port_out,
    output logic                   port_change_flag
);

    initial begin
        if (PC_W < K11_W) $error("PC_W must hold an eleven-bit jump target.");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        phase_e                         q;
        logic                           run;
        logic [PC_W-1:0]                pc;
        logic [IW_W-1:0]                ir;
        logic                           flush;
        logic [DATA_W-1:0]              acc;
        logic                           z;
        logic [DATA_W-1:0]              opnd;
        logic [DATA_W-1:0]              pin_meta;
        logic [DATA_W-1:0]              pin_sync;
        logic [DATA_W-1:0]              port_seen;
        logic                           pchg;
        logic [31:0]                    rdata;
        logic [FILE_N-1:0][DATA_W-1:0]  file;
    } state_s;

    localparam state_s RST_STATE = '{q: PH_Q1, default: '0};

    state_s s;
    state_s next_s;

    class_e             cls;
    op_e                op;
    logic [FADDR_W-1:0] f_addr;
    logic               dst;
    logic [BSEL_W-1:0]  bsel;
    logic [K8_W-1:0]    k8;
    logic [K11_W-1:0]   k11;

    instr_field_decode u_dec (
        .word   (s.ir),
        .cls    (cls),
        .op     (op),
        .f_addr (f_addr),
        .dst    (dst),
        .bsel   (bsel),
        .k8     (k8),
        .k11    (k11)
    );

    // The port reads the synchronised pins; every other index is storage.
    function automatic logic [DATA_W-1:0] file_rd(input state_s st,
                                                  input logic [FADDR_W-1:0] a);
        return (a == PORT_ADDR) ? st.pin_sync : st.file[a];
    endfunction : file_rd

    logic exec;
    logic setup;
    logic wr_clr;
    assign exec  = (s.q == PH_Q4) && !s.flush;
    assign setup = psel && !penable;
    assign wr_clr = psel && penable && pwrite && (paddr == ADDR_STAT)
                    && pwdata[STAT_PCHG];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [DATA_W-1:0] res;
        logic              wr_f;
        logic              wr_a;
        logic              zupd;
        res  = '0;
        wr_f = 1'b0;
        wr_a = 1'b0;
        zupd = 1'b0;
        next_s = s;
        next_s.pin_meta = second_io_port_in;
        next_s.pin_sync = s.pin_meta;
        // Set wins over a software clear in the same cycle.
        next_s.pchg = (s.pchg && !wr_clr) || (s.pin_sync != s.port_seen);

        // Four clocks per instruction cycle; a started cycle always completes.
        if (s.run || s.q != PH_Q1) begin
            case (s.q)
                PH_Q1: next_s.q = PH_Q2;
                PH_Q2: next_s.q = PH_Q3;
                PH_Q3: next_s.q = PH_Q4;
                PH_Q4: next_s.q = PH_Q1;
                default: next_s.q = PH_Q1;
            endcase
        end

        case (s.q)
            PH_Q1: if (s.run) next_s.ir = prog_word;
            PH_Q2: if (cls != CLS_LIT && !s.flush) begin
                next_s.opnd = file_rd(s, f_addr);
                if (f_addr == PORT_ADDR) next_s.port_seen = s.pin_sync;
            end
            PH_Q4: begin
                // A flushed cycle holds the counter: a jump target is fetched again, and a
                // taken skip has already stepped over the word that it discards.
                next_s.pc = s.flush ? s.pc : PC_W'(s.pc + 1'b1);
                next_s.flush = 1'b0;
                if (exec) begin
                    case (op)
                        OP_STORE: begin
                            res = s.acc;
                            wr_f = 1'b1;
                        end
                        OP_CLEAR: begin
                            wr_f = 1'b1;
                            zupd = 1'b1;
                        end
                        OP_ORWF: begin
                            res = s.acc | s.opnd;
                            wr_f = dst;
                            wr_a = !dst;
                            zupd = 1'b1;
                        end
                        OP_MOVE_FILE_VALUE: begin
                            res = s.opnd;
                            wr_f = dst;
                            wr_a = !dst;
                            zupd = 1'b1;
                        end
                        OP_BSKIP: begin
                            next_s.flush = s.opnd[bsel];
                            if (s.opnd[bsel]) next_s.pc = PC_W'(s.pc + 2'd2);
                        end
                        OP_JUMP: begin
                            next_s.pc = PC_W'(k11);
                            next_s.flush = 1'b1;
                        end
                        OP_LDLIT: begin
                            res = k8;
                            wr_a = 1'b1;
                        end
                        OP_ORLIT: begin
                            res = s.acc | k8;
                            wr_a = 1'b1;
                            zupd = 1'b1;
                        end
                        default: ;
                    endcase
                    if (wr_f) next_s.file[f_addr] = res;
                    if (wr_a) next_s.acc = res;
                    if (zupd) next_s.z = (res == '0);
                end
            end
            default: ;
        endcase

        // APB: read data is sampled in the setup phase, writes land in access.
        if (setup && !pwrite) begin
            case (paddr)
                ADDR_CTRL: next_s.rdata = 32'(s.run);
                ADDR_STAT: next_s.rdata = 32'({s.flush, s.pchg, s.z});
                ADDR_ACC:  next_s.rdata = 32'(s.acc);
                ADDR_PC:   next_s.rdata = 32'(s.pc);
                ADDR_IR:   next_s.rdata = 32'(s.ir);
                default:   next_s.rdata = '0;
            endcase
        end
        if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
            next_s.run = pwdata[CTRL_RUN];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata             = s.rdata;
    assign pready             = 1'b1;
    assign pslverr            = psel && penable && !(paddr inside
                                {ADDR_CTRL, ADDR_STAT, ADDR_ACC, ADDR_PC, ADDR_IR});
    assign program_counter    = s.pc;
    assign second_io_port_out = s.file[PORT_ADDR];
    assign port_change_flag   = s.pchg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_q2_q4;
        s.q == PH_Q2 ##1 s.q == PH_Q3 ##1 s.q == PH_Q4;
    endsequence

    chk_phase_four: assert property (
        (s.q == PH_Q1 && s.run) |=> seq_q2_q4 ##1 s.q == PH_Q1)
        else $error("Instruction cycle is not four clocks.");

    chk_orlit_zero: assert property (
        (exec && op == OP_ORLIT) |=> s.acc == $past(s.acc | k8)
            && s.z == ($past(s.acc | k8) == '0))
        else $error("OR-literal result or zero flag wrong.");

    chk_ldlit_flags: assert property (
        (exec && op == OP_LDLIT) |=> s.acc == $past(k8) && $stable(s.z))
        else $error("Load literal wrong or touched flags.");

    chk_store_file: assert property (
        (exec && op == OP_STORE && f_addr != PORT_ADDR)
            |=> s.file[$past(f_addr)] == $past(s.acc) && $stable(s.z))
        else $error("Store to file failed.");

    chk_orwf_dest: assert property (
        (exec && op == OP_ORWF && !dst) |=> s.acc == $past(s.acc | s.opnd))
        else $error("OR with file missed accumulator.");

    chk_move_file_value_zero: assert property (
        (exec && op == OP_MOVE_FILE_VALUE) |=> s.z == ($past(s.opnd) == '0))
        else $error("Move file did not update zero.");

    chk_jump_flush: assert property (
        (exec && op == OP_JUMP) |=> s.flush && s.pc == PC_W'($past(k11))
            ##4 !s.flush)
        else $error("Jump did not flush one cycle.");

    chk_flush_idle: assert property (
        (s.q == PH_Q4 && s.flush) |=> $stable(s.acc) && $stable(s.z))
        else $error("Flushed cycle changed state.");

    chk_idle_stable: assert property (
        (exec && op == OP_IDLE) |=> $stable(s.acc) && $stable(s.z)
            && s.pc == PC_W'($past(s.pc) + 1'b1))
        else $error("Idle instruction changed state.");

    chk_port_read: assert property (
        (s.q == PH_Q2 && !s.flush && cls != CLS_LIT && f_addr == PORT_ADDR)
            |=> s.port_seen == $past(s.pin_sync))
        else $error("Port access did not sample the pins.");

    chk_skip_taken: assert property (
        (exec && op == OP_BSKIP && s.opnd[bsel]) |=> s.flush
            && s.pc == PC_W'($past(s.pc) + 2'd2))
        else $error("Taken skip did not pass over one word.");

    chk_clear_zero: assert property (
        (exec && op == OP_CLEAR) |=> s.z && s.file[$past(f_addr)] == '0)
        else $error("Clear did not zero the file register.");

    chk_pchg_set: assert property (
        (s.pin_sync != s.port_seen) |=> s.pchg)
        else $error("Port mismatch did not raise the change flag.");

    chk_fetch_word: assert property (
        (s.q == PH_Q1 && s.run) |=> s.ir == $past(prog_word))
        else $error("Instruction word not latched at fetch.");

    // The file-destination path of the OR is checked apart from the accumulator path.
    chk_orwf_file: assert property (
        (exec && op == OP_ORWF && dst)
            |=> s.file[$past(f_addr)] == $past(s.acc | s.opnd))
        else $error("OR with file missed the file register.");

endmodule : instr_exec_core

// >>> verification/prog_rom.sv
// Program memory model that hands instruction words to the core.
`timescale 1ns/1ps
module prog_rom
    import exec_pkg::*;
#(
    parameter int AW = K11_W
) (
    input  wire logic [AW-1:0] addr,
    output logic [IW_W-1:0]    word
);
    // ------------------------------------------------------------
    // Storage, loaded by the bench while the core is held in reset
    // ------------------------------------------------------------
    logic [IW_W-1:0] mem [2**AW];

    initial begin
        foreach (mem[i]) begin
            mem[i] = '0;
        end
    end

    // A combinational read keeps the word settled long before the Q1 edge.
    assign word = mem[addr];
endmodule : prog_rom

// >>> verification/mcu_instruction_decode_exec_tb.sv
// Self-checking testbench of the instruction core and its register bus.
`timescale 1ns/1ps
module mcu_instruction_decode_exec_tb
    import exec_pkg::*;
;
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [K11_W-1:0]  program_counter;
    logic [IW_W-1:0]   prog_word;
    logic [DATA_W-1:0] second_io_port_in;
    logic [DATA_W-1:0] second_io_port_out;
    logic              port_change_flag;
    logic [31:0]       rd;
    logic              err;
    logic [IW_W-1:0]   prog [$];
    int                n_fail;
    int                checks;

    always #2 pclk = ~pclk;

    instr_exec_core dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .program_counter(program_counter),
        .prog_word(prog_word), .second_io_port_in(second_io_port_in),
        .second_io_port_out(second_io_port_out), .port_change_flag(port_change_flag)
    );

    prog_rom rom (.addr(program_counter), .word(prog_word));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Restarts the core with a fresh program; the rest of memory idles.
    task automatic load_and_run();
        presetn <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            rom.mem[i] = (i < prog.size()) ? prog[i] : '0;
        end
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h1);
    endtask : load_and_run

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, ADDR_ACC, 32'hff);
        apb(1'b0, ADDR_ACC, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h1);
    endtask : t_regs

    // Program's last data step is a load of zero, so the zero flag must keep the move's result.
    task automatic t_data();
        logic [K11_W-1:0] p;
        int               n;
        prog = '{14'h335a, 14'h00ff, 14'h3000, 14'h087f, 14'h3000, 14'h3800, 14'h3081,
                 14'h04ff, 14'h087f, 14'h0086, 14'h3000, 14'h0060, 14'h280c};
        load_and_run();
        for (int k = 0; k < 2; k++) begin
            p = program_counter;
            n = 0;
            while (program_counter === p && n < 20) begin
                @(posedge pclk);
                n++;
            end
        end
        chk(n, 4);
        repeat (80) @(posedge pclk);
        apb(1'b0, ADDR_ACC, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rd & 32'h3, 32'h0);
        chk(second_io_port_out, 8'hdb);
        apb(1'b0, ADDR_IR, 32'h0);
        chk(rd, 32'h280c);
    endtask : t_data

    task automatic t_skip();
        prog = '{14'h3001, 14'h00a1, 14'h1c21, 14'h30ee, 14'h2806, 14'h30ee,
                 14'h3802, 14'h1ca1, 14'h3804, 14'h2809};
        load_and_run();
        repeat (100) @(posedge pclk);
        apb(1'b0, ADDR_ACC, 32'h0);
        chk(rd, 32'h7);
    endtask : t_skip

    // Clearing the port must also read it, which settles the mismatch.
    task automatic t_port();
        second_io_port_in <= 8'h3c;
        prog = '{14'h0186, 14'h3800, 14'h2802};
        repeat (8) @(posedge pclk);
        chk(port_change_flag, 1'b1);
        load_and_run();
        repeat (40) @(posedge pclk);
        apb(1'b1, ADDR_STAT, 32'h2);
        repeat (8) @(posedge pclk);
        chk(port_change_flag, 1'b0);
        chk(second_io_port_out, 8'h00);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rd & 32'h3, 32'h1);
        second_io_port_in <= 8'h3d;
        repeat (8) @(posedge pclk);
        chk(port_change_flag, 1'b1);
    endtask : t_port

    // ------------------------------------------------------------
    // Sequence and verdict
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        second_io_port_in = 8'h00;
        n_fail = 0;
        checks = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_data();
        t_skip();
        t_port();
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        report_and_stop();
    end
endmodule : mcu_instruction_decode_exec_tb
